/* File: tol_pkg.sv */
// constants, carriers and helpers of the thermal overload limiter
// Summary of operation
// - overload limiting only happens while closed loop (submode bit 0) is set
// - limiter enabled in open loop caps current at rated current
// - peak current parameter in mA, allowed while budget remains
// - rated current parameter in mA, applied once budget is used up
// - peak time parameter in ms, longest run at peak current
// - readable threshold decides peak or rated limit
// - readable overload accumulator compared against the threshold
// - applied current limit is readable
// - active only with closed loop, peak above rated, nonzero time
// - threshold derived from rated current, peak current and peak time
// - peak allowed until accumulator reaches threshold, then rated at once
// - accumulator drains by samples below rated current between overcurrent episodes, floored at zero
// - submode bit 2 selects automatic brake, else output control bit 0
package tol_pkg;

   localparam int CUR_W  = 16;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 8;

   // register offsets
   localparam logic [ADDR_W-1:0] REG_SUBMODE   = 8'h00;
   localparam logic [ADDR_W-1:0] REG_PEAK      = 8'h04;
   localparam logic [ADDR_W-1:0] REG_RATED     = 8'h08;
   localparam logic [ADDR_W-1:0] REG_PEAK_TIME = 8'h0c;
   localparam logic [ADDR_W-1:0] REG_THRESHOLD = 8'h10;
   localparam logic [ADDR_W-1:0] REG_ACCUM     = 8'h14;
   localparam logic [ADDR_W-1:0] REG_LIMIT     = 8'h18;
   localparam logic [ADDR_W-1:0] REG_STATUS    = 8'h1c;
   localparam logic [ADDR_W-1:0] REG_CTRL      = 8'h20;
   localparam logic [ADDR_W-1:0] REG_OUTCTRL   = 8'h24;

   // field positions
   localparam int SUB_CLOSED_BIT = 0;
   localparam int SUB_BRAKE_BIT  = 2;
   localparam int CTRL_EN_BIT    = 0;
   localparam int OUT_BRAKE_BIT  = 0;
   localparam int STAT_ACT_BIT   = 0;

   // reset values
   localparam logic [CUR_W-1:0]  RST_CUR  = 16'h0000;
   localparam logic [DATA_W-1:0] RST_WORD = 32'h0000_0000;

   // squares are kept in units of mA squared divided by 2**16
   localparam int SQ_SHIFT = 16;

   typedef struct packed {
      logic             enable;
      logic             closed_loop;
      logic             auto_brake;
      logic [CUR_W-1:0] peak;
      logic [CUR_W-1:0] rated;
      logic [CUR_W-1:0] ptime;
   } tol_cfg_t;

   typedef struct packed {
      logic             valid;
      logic [CUR_W-1:0] current;
   } tol_sample_t;

   function automatic logic [CUR_W-1:0] tol_sq(input logic [CUR_W-1:0] a);
      logic [2*CUR_W-1:0] p;
      p = {{CUR_W{1'b0}}, a} * {{CUR_W{1'b0}}, a};
      return p[2*CUR_W-1:SQ_SHIFT];
   endfunction

endpackage

/* File: tol_accum.sv */
// overload accumulator with squared excess update and zero floor
`timescale 1ns/1ps
`default_nettype none
module tol_accum
   import tol_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic              reset_n_i,
   input  wire tol_sample_t       sample_i,
   input  wire logic              run_i,
   input  wire logic [CUR_W-1:0]  rated_sq_i,
   output logic      [DATA_W-1:0] acc_o
);

   logic [CUR_W-1:0]  meas_sq;
   logic              over;
   logic [DATA_W-1:0] diff;
   logic [DATA_W:0]   sum;
   logic              step;
   logic [DATA_W-1:0] next_acc;

   ////////////////////////////////////////////////////////////////////////
   // squared excess update
   assign meas_sq  = tol_sq(sample_i.current);
   assign over     = meas_sq > rated_sq_i;
   assign diff     = over ? {16'h0000, meas_sq - rated_sq_i}
                          : {16'h0000, rated_sq_i - meas_sq};
   assign sum      = {1'b0, acc_o} + {1'b0, diff};
   assign step     = run_i && sample_i.valid;
   // only a sample step moves it
   assign next_acc = !step ? acc_o
                   : over  ? (sum[DATA_W] ? {DATA_W{1'b1}} : sum[DATA_W-1:0])
                   : (acc_o > diff ? acc_o - diff : RST_WORD);

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         acc_o <= RST_WORD;
      end else begin
         acc_o <= next_acc;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   AST_NO_CLEAR: assert property (!step |=> $stable(acc_o))
      else $error("accumulator moved without a sample");
   AST_FLOOR: assert property (step && !over && acc_o <= diff |=>
      acc_o == 32'h0000_0000)
      else $error("accumulator did not floor at zero");
   AST_RISE: assert property (step && over && !sum[DATA_W] |=>
      acc_o == $past(acc_o) + $past(diff))
      else $error("accumulator did not add excess");

   COV_FLOOR: cover property (step && !over && acc_o != 0 ##1 acc_o == 0);

endmodule
`default_nettype wire

/* File: tol_limiter.sv */
// thermal overload limiter top with register port and current limit
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/1ps
`default_nettype none
module tol_limiter
   import tol_pkg::*;
(
   input  wire logic              ref_clk_i,
   input  wire logic              reset_n_i,
   input  wire logic [ADDR_W-1:0] reg_addr_i,
   input  wire logic [DATA_W-1:0] reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic      [DATA_W-1:0] reg_rdata_o,
   input  wire tol_sample_t       sample_i,
   input  wire logic              brake_auto_release_i,
   output logic      [CUR_W-1:0]  current_limit_o,
   output logic                   limiter_active_o,
   output logic                   brake_release_o
);

   ////////////////////////////////////////////////////////////////////////
   // register state
   tol_cfg_t          cfg;
   logic              out_brake;
   logic [DATA_W-1:0] threshold;
   logic [DATA_W-1:0] accum;

   logic              wr_sub;
   logic              wr_peak;
   logic              wr_rated;
   logic              wr_time;
   logic              wr_ctrl;
   logic              wr_out;
   logic [CUR_W-1:0]  wlo;

   assign wlo      = reg_wdata_i[CUR_W-1:0];
   assign wr_sub   = reg_wr_i && reg_addr_i == REG_SUBMODE;
   assign wr_peak  = reg_wr_i && reg_addr_i == REG_PEAK;
   assign wr_rated = reg_wr_i && reg_addr_i == REG_RATED;
   assign wr_time  = reg_wr_i && reg_addr_i == REG_PEAK_TIME;
   assign wr_ctrl  = reg_wr_i && reg_addr_i == REG_CTRL;
   assign wr_out   = reg_wr_i && reg_addr_i == REG_OUTCTRL;

   // mode bits
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         cfg.closed_loop <= 1'b0;
         cfg.auto_brake  <= 1'b0;
         cfg.enable      <= 1'b0;
         out_brake       <= 1'b0;
      end else begin
         if (wr_sub) begin
            cfg.closed_loop <= reg_wdata_i[SUB_CLOSED_BIT];
            cfg.auto_brake  <= reg_wdata_i[SUB_BRAKE_BIT];
         end
         if (wr_ctrl) begin
            cfg.enable <= reg_wdata_i[CTRL_EN_BIT];
         end
         if (wr_out) begin
            out_brake <= reg_wdata_i[OUT_BRAKE_BIT];
         end
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         cfg.peak <= RST_CUR;
      end else if (wr_peak) begin
         cfg.peak <= wlo;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         cfg.rated <= RST_CUR;
      end else if (wr_rated) begin
         cfg.rated <= wlo;
      end
   end

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         cfg.ptime <= RST_CUR;
      end else if (wr_time) begin
         cfg.ptime <= wlo;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // activation and threshold
   logic [CUR_W-1:0]  peak_sq;
   logic [CUR_W-1:0]  rated_sq;
   logic              cond_ok;
   logic              next_active;
   logic [DATA_W-1:0] next_threshold;

   assign peak_sq  = tol_sq(cfg.peak);
   assign rated_sq = tol_sq(cfg.rated);

   assign cond_ok     = cfg.closed_loop && (cfg.peak > cfg.rated) &&
                        (cfg.ptime != 16'h0000);
   assign next_active = cfg.enable && cond_ok;

   // budget from both currents and time
   assign next_threshold = cond_ok
      ? {16'h0000, peak_sq - rated_sq} * {16'h0000, cfg.ptime}
      : RST_WORD;

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         threshold        <= RST_WORD;
         limiter_active_o <= 1'b0;
      end else begin
         threshold        <= next_threshold;
         limiter_active_o <= next_active;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // accumulator
   tol_accum u_accum (
      .ref_clk_i  (ref_clk_i),
      .reset_n_i  (reset_n_i),
      .sample_i   (sample_i),
      .run_i      (limiter_active_o),
      .rated_sq_i (rated_sq),
      .acc_o      (accum)
   );

   ////////////////////////////////////////////////////////////////////////
   // current limit selection
   logic             spent;
   logic             open_cap;
   logic [CUR_W-1:0] next_limit;

   assign spent      = accum >= threshold;
   assign open_cap   = cfg.enable && !cfg.closed_loop;
   assign next_limit = open_cap         ? cfg.rated
                     : limiter_active_o ? (spent ? cfg.rated : cfg.peak)
                     :                    cfg.peak;

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         current_limit_o <= RST_CUR;
      end else begin
         current_limit_o <= next_limit;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // brake selection
   // automatic or manual brake
   assign brake_release_o = cfg.auto_brake ? brake_auto_release_i
                                           : out_brake;

   ////////////////////////////////////////////////////////////////////////
   // register read port
   logic [DATA_W-1:0] rd_mux;
   logic [DATA_W-1:0] sub_word;

   assign sub_word = {29'h0, cfg.auto_brake, 1'b0, cfg.closed_loop};

   assign rd_mux =
        reg_addr_i == REG_SUBMODE   ? sub_word
      : reg_addr_i == REG_PEAK      ? {16'h0000, cfg.peak}
      : reg_addr_i == REG_RATED     ? {16'h0000, cfg.rated}
      : reg_addr_i == REG_PEAK_TIME ? {16'h0000, cfg.ptime}
      : reg_addr_i == REG_THRESHOLD ? threshold
      : reg_addr_i == REG_ACCUM     ? accum
      : reg_addr_i == REG_LIMIT     ? {16'h0000, current_limit_o}
      : reg_addr_i == REG_STATUS    ? {31'h0, limiter_active_o}
      : reg_addr_i == REG_CTRL      ? {31'h0, cfg.enable}
      : reg_addr_i == REG_OUTCTRL   ? {31'h0, out_brake}
      :                               RST_WORD;

   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i) begin
         reg_rdata_o <= RST_WORD;
      end else begin
         reg_rdata_o <= reg_rd_i ? rd_mux : RST_WORD;
      end
   end

   ////////////////////////////////////////////////////////////////////////
   // checks
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!reset_n_i);

   AST_CLOSED_ONLY: assert property (
      limiter_active_o |-> $past(cfg.closed_loop))
      else $error("limiter active outside closed loop");

   AST_OPEN_CAP: assert property (
      open_cap |=> current_limit_o == $past(cfg.rated))
      else $error("open loop limit is not the rated current");

   AST_PEAK_HELD: assert property (
      wr_peak ##1 !wr_peak |=> cfg.peak == $past(reg_wdata_i[15:0], 2))
      else $error("peak current not stored");

   AST_RATED_HELD: assert property (
      wr_rated |=> reg_rd_i && reg_addr_i == REG_RATED
                   |=> reg_rdata_o[15:0] == $past(cfg.rated))
      else $error("rated current readback wrong");

   AST_TIME_HELD: assert property (
      wr_time |=> cfg.ptime == $past(reg_wdata_i[15:0]))
      else $error("peak time not stored");

   AST_THR_READ: assert property (
      reg_rd_i && reg_addr_i == REG_THRESHOLD
      |=> reg_rdata_o == $past(threshold))
      else $error("threshold readback wrong");

   AST_ACC_READ: assert property (
      reg_rd_i && reg_addr_i == REG_ACCUM |=> reg_rdata_o == $past(accum))
      else $error("accumulator readback wrong");

   AST_LIMIT_READ: assert property (
      reg_rd_i && reg_addr_i == REG_LIMIT
      |=> reg_rdata_o[15:0] == $past(current_limit_o))
      else $error("limit readback wrong");

   AST_ACTIVE: assert property (
      cfg.enable && cond_ok |=> limiter_active_o)
      else $error("limiter failed to activate");

   AST_INACTIVE: assert property (
      !(cfg.enable && cond_ok) |=> !limiter_active_o)
      else $error("limiter active without its conditions");

   AST_THR_ZERO: assert property (
      !cond_ok |=> threshold == 32'h0000_0000)
      else $error("threshold set without valid parameters");

   AST_DROP: assert property (
      limiter_active_o && !open_cap && spent
      |=> current_limit_o == $past(cfg.rated))
      else $error("limit not dropped to rated current");

   AST_PEAK_OK: assert property (
      limiter_active_o && !open_cap && !spent
      |=> current_limit_o == $past(cfg.peak))
      else $error("peak not allowed while budget remains");

   AST_BRAKE: assert property (
      !cfg.auto_brake |-> brake_release_o == out_brake)
      else $error("manual brake not following output bit");

   AST_BRAKE_AUTO: assert property (
      cfg.auto_brake |-> brake_release_o == brake_auto_release_i)
      else $error("automatic brake not following release request");

   ////////////////////////////////////////////////////////////////////////
   // values after reset
   AST_RST_LIMIT: assert property (disable iff (1'b0)
      !reset_n_i |=> current_limit_o == RST_CUR)
      else $error("limit not cleared by reset");

   AST_RST_ACTIVE: assert property (disable iff (1'b0)
      !reset_n_i |=> !limiter_active_o)
      else $error("limiter active after reset");

   AST_RST_RDATA: assert property (disable iff (1'b0)
      !reset_n_i |=> reg_rdata_o == RST_WORD)
      else $error("read data not cleared by reset");

   AST_RST_ACCUM: assert property (disable iff (1'b0)
      !reset_n_i |=> accum == RST_WORD)
      else $error("accumulator not cleared by reset");

   ////////////////////////////////////////////////////////////////////////
   // register port
   AST_RD_IDLE: assert property (
      !reg_rd_i |=> reg_rdata_o == RST_WORD)
      else $error("read data not zero outside a read");

   AST_STAT_READ: assert property (
      reg_rd_i && reg_addr_i == REG_STATUS
      |=> reg_rdata_o == {31'h0, $past(limiter_active_o)})
      else $error("status readback wrong");

   AST_SUB_READ: assert property (
      reg_rd_i && reg_addr_i == REG_SUBMODE |=> reg_rdata_o ==
      {29'h0, $past(cfg.auto_brake), 1'b0, $past(cfg.closed_loop)})
      else $error("submode readback wrong");

   AST_PEAK_READ: assert property (
      reg_rd_i && reg_addr_i == REG_PEAK
      |=> reg_rdata_o == {16'h0000, $past(cfg.peak)})
      else $error("peak current readback wrong");

   AST_TIME_READ: assert property (
      reg_rd_i && reg_addr_i == REG_PEAK_TIME
      |=> reg_rdata_o == {16'h0000, $past(cfg.ptime)})
      else $error("peak time readback wrong");

   AST_EN_READ: assert property (
      reg_rd_i && reg_addr_i == REG_CTRL
      |=> reg_rdata_o == {31'h0, $past(cfg.enable)})
      else $error("enable readback wrong");

   AST_OUT_READ: assert property (
      reg_rd_i && reg_addr_i == REG_OUTCTRL
      |=> reg_rdata_o == {31'h0, $past(out_brake)})
      else $error("output control readback wrong");

   AST_SUB_HELD: assert property (
      wr_sub |=> cfg.closed_loop == $past(reg_wdata_i[SUB_CLOSED_BIT]))
      else $error("closed loop bit not stored");

   AST_AUTO_HELD: assert property (
      wr_sub |=> cfg.auto_brake == $past(reg_wdata_i[SUB_BRAKE_BIT]))
      else $error("brake mode bit not stored");

   AST_EN_HELD: assert property (
      wr_ctrl |=> cfg.enable == $past(reg_wdata_i[CTRL_EN_BIT]))
      else $error("enable bit not stored");

   AST_OUT_HELD: assert property (
      wr_out |=> out_brake == $past(reg_wdata_i[OUT_BRAKE_BIT]))
      else $error("manual brake bit not stored");

   AST_RATED_STORE: assert property (
      wr_rated |=> cfg.rated == $past(wlo))
      else $error("rated current not stored");

   ////////////////////////////////////////////////////////////////////////
   // limit and accumulator
   AST_ACC_HOLD: assert property (
      !limiter_active_o |=> $stable(accum))
      else $error("accumulator moved while limiter inactive");

   AST_IDLE_PEAK: assert property (
      !limiter_active_o && !open_cap |=> current_limit_o == $past(cfg.peak))
      else $error("inactive limiter not passing peak current");

   COV_ACTIVE: cover property (!limiter_active_o ##1 limiter_active_o);
   COV_DROP:   cover property (limiter_active_o && !spent ##1 spent);
   COV_OPEN:   cover property (open_cap ##1 cfg.peak > cfg.rated);
   COV_AUTO:   cover property (cfg.auto_brake && brake_auto_release_i);

endmodule
`default_nettype wire

/* File: tol_regulator_model.sv */
// motor current regulator model producing periodic current samples
`timescale 1ns/1ps
`default_nettype none
module tol_regulator_model
   import tol_pkg::*;
#(
   parameter int PERIOD = 4
)(
   input  wire logic             ref_clk_i,
   input  wire logic             reset_n_i,
   input  wire logic             run_i,
   input  wire logic [CUR_W-1:0] demand_i,
   input  wire logic [CUR_W-1:0] limit_i,
   output var  tol_sample_t      sample_o
);
   int               cnt;
   logic             fire;
   logic [CUR_W-1:0] meas;
   ////////////////////////////////////////////////////////////////////
   // obeys applied limit
   assign meas = (demand_i < limit_i) ? demand_i : limit_i;
   assign fire = reset_n_i && run_i && (cnt == PERIOD - 1);
   always_ff @(posedge ref_clk_i) begin
      if (!reset_n_i || !run_i) begin
         cnt <= 0;
      end else begin
         cnt <= fire ? 0 : cnt + 1;
      end
      sample_o.valid <= fire;
      // current toggles when not valid
      sample_o.current <= !reset_n_i ? '0 :
                          fire ? meas : ~sample_o.current;
   end
endmodule
`default_nettype wire

/* File: testbench.sv */
// self-checking testbench of the thermal overload limiter
`timescale 1ns/1ps
`default_nettype none
module testbench
   import tol_pkg::*;
;
   localparam int PK  = 4096;
   localparam int RT  = 2048;
   localparam int THR = ((PK * PK >> 16) - (RT * RT >> 16)) * 10;
   logic              ref_clk_i = 1'b0;
   logic              reset_n_i = 1'b0;
   logic              reg_wr_i  = 1'b0;
   logic              reg_rd_i  = 1'b0;
   logic              brake_auto_release_i = 1'b0;
   logic              run = 1'b0;
   logic [ADDR_W-1:0] reg_addr_i = '0;
   logic [DATA_W-1:0] reg_wdata_i = '0;
   logic [DATA_W-1:0] reg_rdata_o;
   logic [DATA_W-1:0] rv;
   logic [CUR_W-1:0]  demand = 16'h1000;
   logic [CUR_W-1:0]  current_limit_o;
   logic              limiter_active_o;
   logic              brake_release_o;
   tol_sample_t       sample;
   int                failures = 0;
   int                cmp_count = 0;
   int                n_samp = 0;
   int                cyc = 0;
   ////////////////////////////////////////////////////////////////////
   tol_limiter u_tol_limiter (.ref_clk_i(ref_clk_i), .reset_n_i(reset_n_i),
      .reg_addr_i(reg_addr_i), .reg_wdata_i(reg_wdata_i),
      .reg_wr_i(reg_wr_i), .reg_rd_i(reg_rd_i), .reg_rdata_o(reg_rdata_o),
      .sample_i(sample), .brake_auto_release_i(brake_auto_release_i),
      .current_limit_o(current_limit_o),
      .limiter_active_o(limiter_active_o),
      .brake_release_o(brake_release_o));
   tol_regulator_model u_tol_regulator_model (.ref_clk_i(ref_clk_i),
      .reset_n_i(reset_n_i), .run_i(run), .demand_i(demand),
      .limit_i(current_limit_o), .sample_o(sample));
   always #5 ref_clk_i = ~ref_clk_i;
   always @(posedge ref_clk_i) begin
      if (sample.valid === 1'b1) n_samp <= n_samp + 1;
      cyc <= cyc + 1;
      if (cyc == 20000) begin
         failures++;
         print_verdict();
      end
   end
   ////////////////////////////////////////////////////////////////////
   task automatic chk(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
      cmp_count++;
      if (got !== exp) begin
         failures++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   task automatic cyc_n(input int n);
      repeat (n) @(posedge ref_clk_i);
      #1;
   endtask
   task automatic wr(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_wdata_i <= d;
      reg_wr_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_wr_i <= 1'b0;
   endtask
   task automatic rchk(input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] e);
      @(posedge ref_clk_i);
      reg_addr_i <= a;
      reg_rd_i <= 1'b1;
      @(posedge ref_clk_i);
      reg_rd_i <= 1'b0;
      #1 rv = reg_rdata_o;
      chk(rv, e);
   endtask
   task automatic go(input int n);
      int k;
      k = 0;
      n = n + n_samp;
      @(posedge ref_clk_i);
      run <= 1'b1;
      while (n_samp < n && k < 400) begin
         @(posedge ref_clk_i);
         #1 k++;
      end
      @(posedge ref_clk_i);
      run <= 1'b0;
      cyc_n(3);
   endtask
   task automatic print_verdict();
      $display("failures=%0d cmp_count=%0d", failures, cmp_count);
      if (failures == 0 && cmp_count > 0) $display("Test passed");
      else $display("Test failed");
      $finish;
   endtask
   ////////////////////////////////////////////////////////////////////
   task automatic t_regs();
      chk(32'(current_limit_o), 32'h0);
      rchk(REG_PEAK, 32'h0);
      wr(REG_PEAK, 32'hffff_1000);
      wr(REG_RATED, 32'(RT));
      wr(REG_PEAK_TIME, 32'h0000_000a);
      wr(REG_THRESHOLD, 32'h0000_5555);
      rchk(REG_PEAK, 32'(PK));
      chk(reg_rdata_o, 32'(PK));
      cyc_n(1);
      chk(reg_rdata_o, 32'h0);
      rchk(REG_RATED, 32'(RT));
      rchk(REG_PEAK_TIME, 32'h0000_000a);
      rchk(REG_THRESHOLD, 32'h0);
      rchk(8'h3c, 32'h0);
   endtask
   task automatic t_activate();
      int sub[4] = '{0, 1, 1, 1};
      int rat[4] = '{RT, PK, RT, RT};
      int pt[4]  = '{10, 10, 0, 10};
      wr(REG_CTRL, 32'h1);
      for (int i = 0; i < 4; i++) begin
         wr(REG_SUBMODE, 32'(sub[i]));
         wr(REG_RATED, 32'(rat[i]));
         wr(REG_PEAK_TIME, 32'(pt[i]));
         cyc_n(3);
         chk(32'(limiter_active_o), 32'(i == 3));
         rchk(REG_STATUS, 32'(i == 3));
         chk(32'(current_limit_o), 32'(i ? PK : RT));
      end
      rchk(REG_THRESHOLD, 32'(THR));
   endtask
   task automatic t_budget();
      go(9);
      rchk(REG_ACCUM, 32'(9 * (THR / 10)));
      chk(32'(current_limit_o), 32'(PK));
      go(1);
      chk(32'(current_limit_o), 32'(RT));
      rchk(REG_LIMIT, 32'(RT));
      demand <= 16'h0400;
      go(2);
      rchk(REG_ACCUM, 32'(THR - 2 * (64 - 16)));
      chk(32'(current_limit_o), 32'(PK));
      demand <= 16'h1000;
      go(1);
      chk(32'(current_limit_o), 32'(RT));
      demand <= 16'h0000;
      go(40);
      rchk(REG_ACCUM, 32'h0);
   endtask
   task automatic t_open();
      wr(REG_SUBMODE, 32'h0);
      cyc_n(3);
      chk(32'(current_limit_o), 32'(RT));
      demand <= 16'h1000;
      go(3);
      rchk(REG_ACCUM, 32'h0);
      wr(REG_CTRL, 32'h0);
      cyc_n(3);
      chk(32'(current_limit_o), 32'(PK));
   endtask
   task automatic t_brake();
      for (int i = 0; i < 4; i++) begin
         wr(REG_SUBMODE, i[1] ? 32'h4 : 32'h0);
         wr(REG_OUTCTRL, 32'(i[0]));
         brake_auto_release_i <= ~i[0];
         cyc_n(2);
         chk(32'(brake_release_o), 32'(i[1] ^ i[0]));
      end
   endtask
   ////////////////////////////////////////////////////////////////////
   initial begin
      cyc_n(2);
      reset_n_i <= 1'b1;
      t_regs();
      t_activate();
      t_budget();
      t_open();
      t_brake();
      print_verdict();
   end
endmodule
`default_nettype wire
